// ===== core/mqw_pkg.sv
// What this block does
// RULE_01: Two-bit select picks one of four queues; each accepted word goes there.
// RULE_02: Queue select is sampled every rising clock and may change every edge.
// RULE_03: Switching queues costs no idle cycle; back-to-back writes to any queue.
// RULE_04: Each write passes a two-stage pipeline before it is committed to storage.
// RULE_05: After the initial latency one word per clock commits, whatever queue.
// RULE_06: Data taken rising (and falling in DDR) only with enable and select low.
// RULE_07: In DDR enable and chip select are sampled at the rising edge only.
// RULE_08: A select set on one edge governs the write on the very next edge; the code applies it to the write sampled on that same edge.
// RULE_09: A write is accepted every clock for any queue, full bandwidth each.
// RULE_10: In fall-through, a word into an empty, not-ready queue goes out unread.
// RULE_11: Fall-through word reaches the output four clocks after being written.
// RULE_12: Words written to a queue already holding data wait for normal reads.
// RULE_13: In standard mode the reader must request every word, including the first.
// RULE_14: Mode pin held high in reset selects fall-through, low selects standard.
// RULE_15: In DDR one queue word is rising plus falling data, halving queue depth.
// RULE_16: A full selected queue drops input-ready and refuses writes until space.
package mqw_pkg;
  localparam int NUM_QUEUES       = 4;
  localparam int QSEL_W           = 2;
  localparam int DATA_W_DEF       = 40;
  localparam int QUEUE_DEPTH_DEF  = 8192;
  localparam int OUT_FIFO_DEPTH   = 16;
  localparam int SYNC_STAGES      = 2;
  localparam int READ_PIPE_STAGES = 2;
  localparam logic [1:0] CFG_SETTLE = 2'h2;
  localparam logic MODE_STANDARD     = 1'b0;
  localparam logic MODE_FALL_THROUGH = 1'b1;

  typedef enum logic [0:0] {
    MQW_CFG_LATCH = 1'b0,
    MQW_CFG_RUN   = 1'b1
  } mqw_cfg_t;
endpackage

// ===== core/mqw_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module mqw_fifo #(
  parameter int WIDTH = 80,
  parameter int DEPTH = 16
) (
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic      [WIDTH-1:0]           out_data,
  output logic      [$clog2(DEPTH):0]     level
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin
      $error("mqw_fifo DEPTH must be a power of two, at least 4");
    end
  end

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   cnt;
  } mqw_fifo_st_t;

  mqw_fifo_st_t             st;
  mqw_fifo_st_t             next_st;
  logic         [WIDTH-1:0] mem [DEPTH];
  logic                     push;
  logic                     pop;

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = mem[st.rptr];
  assign level     = st.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wptr = st.wptr + AW'(1);
    end
    if (pop) begin
      next_st.rptr = st.rptr + AW'(1);
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[st.wptr] <= in_data;
    end
  end
endmodule // mqw_fifo
`default_nettype wire

// ===== core/mqw_write_port.sv
`timescale 1ns/10ps
`default_nettype none
module mqw_write_port
  import mqw_pkg::*;
#(
  parameter int DATA_W      = mqw_pkg::DATA_W_DEF,
  parameter int QUEUE_DEPTH = mqw_pkg::QUEUE_DEPTH_DEF
) (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic [mqw_pkg::QSEL_W-1:0]    write_queue_select,
  input  wire logic                          wr_en_n,
  input  wire logic                          wr_chip_sel_n,
  input  wire logic [DATA_W-1:0]             wr_data_rise,
  input  wire logic [DATA_W-1:0]             wr_data_fall,
  input  wire logic                          write_double_rate_sel,
  input  wire logic                          mode_serial_in_pin,
  input  wire logic [mqw_pkg::QSEL_W-1:0]    read_queue_select,
  input  wire logic                          rd_en_n,
  input  wire logic                          rd_chip_sel_n,
  output logic      [2*DATA_W-1:0]           out_data,
  output logic      [mqw_pkg::QSEL_W-1:0]    out_queue,
  output logic                               out_valid,
  input  wire logic                          out_ready,
  output logic                               input_ready_flag,
  output logic      [mqw_pkg::NUM_QUEUES-1:0] queue_empty,
  output logic      [mqw_pkg::NUM_QUEUES-1:0] output_ready_flag,
  output logic                               fall_through_mode,
  output logic                               double_rate_mode,
  output logic                               write_refused,
  output logic                               read_refused
);
  import mqw_pkg::*;

  localparam int AW  = $clog2(QUEUE_DEPTH);
  localparam int NQ  = NUM_QUEUES;
  localparam int WW  = 2 * DATA_W;
  localparam int OW  = WW + QSEL_W;
  localparam int FLW = $clog2(OUT_FIFO_DEPTH) + 1;

  initial begin
    if (DATA_W < 1 || QUEUE_DEPTH < 4 || (1 << AW) != QUEUE_DEPTH) begin
      $error("mqw_write_port needs DATA_W >= 1 and a power-of-two QUEUE_DEPTH >= 4");
    end
  end

  typedef struct packed {
    mqw_cfg_t                  cfg;
    logic [1:0]                settle;
    logic                      ft;
    logic                      ddr;
    logic                      mode_s1;
    logic                      mode_s2;
    logic                      ddr_s1;
    logic                      ddr_s2;
    logic [QSEL_W-1:0]         wsel_s1;
    logic [QSEL_W-1:0]         wsel_s2;
    logic                      wen_s1;
    logic                      wen_s2;
    logic [DATA_W-1:0]         rise_s1;
    logic [DATA_W-1:0]         rise_s2;
    logic [DATA_W-1:0]         fall_s1;
    logic [DATA_W-1:0]         fall_s2;
    logic [QSEL_W-1:0]         rsel_s1;
    logic [QSEL_W-1:0]         rsel_s2;
    logic                      ren_s1;
    logic                      ren_s2;
    logic [NQ-1:0][AW-1:0]     wptr;
    logic [NQ-1:0][AW-1:0]     rptr;
    logic [NQ-1:0][AW:0]       cnt;
    logic [NQ-1:0]             oready;
    logic [NQ-1:0]             ft_pend;
    logic                      rp_valid;
    logic [QSEL_W-1:0]         rp_queue;
    logic                      ir;
    logic                      wrefused;
    logic                      rrefused;
  } mqw_st_t;

  mqw_st_t           st;
  mqw_st_t           next_st;
  logic [WW-1:0]     qmem [NQ * QUEUE_DEPTH];
  logic [WW-1:0]     mem_rd;
  logic              mem_we;
  logic [AW+1:0]     mem_waddr;
  logic [WW-1:0]     mem_wdata;
  logic              pop_go;
  logic [QSEL_W-1:0] pop_q;
  logic              fifo_in_ready;
  logic [FLW-1:0]    fifo_level;
  logic              fifo_room;

  // Usable depth: a DDR word packs both edges into one location
  function automatic logic [AW:0] queue_cap(input logic ddr);
    queue_cap = ddr ? (AW+1)'(QUEUE_DEPTH / 2) : (AW+1)'(QUEUE_DEPTH); // RULE_15
  endfunction

  function automatic logic [AW+1:0] mem_addr(input logic [QSEL_W-1:0] q,
                                             input logic [AW-1:0] ptr);
    mem_addr = {q, ptr};
  endfunction

  // Leave space for the word already travelling through the read stage
  assign fifo_room = (fifo_level + FLW'(st.rp_valid) + FLW'(1)) <= FLW'(OUT_FIFO_DEPTH);

  always_comb begin
    logic                   wr_ok;
    logic [QSEL_W-1:0]      wq;
    logic [AW:0]            cnt_eff;
    logic                   ft_found;
    logic [QSEL_W-1:0]      ft_q;
    logic                   user_rd;
    next_st   = st;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    pop_go    = 1'b0;
    pop_q     = '0;
    wr_ok     = 1'b0;
    wq        = st.wsel_s2;
    cnt_eff   = '0;
    ft_found  = 1'b0;
    ft_q      = '0;
    user_rd   = 1'b0;
    next_st.wrefused = 1'b0;
    next_st.rrefused = 1'b0;

    // Pin inputs: two flops before use; the second stage is the second pipeline stage
    next_st.mode_s1 = mode_serial_in_pin;
    next_st.mode_s2 = st.mode_s1;
    next_st.ddr_s1  = write_double_rate_sel;
    next_st.ddr_s2  = st.ddr_s1;
    next_st.wsel_s1 = write_queue_select; // RULE_02
    next_st.wsel_s2 = st.wsel_s1; // RULE_08
    next_st.wen_s1  = !wr_en_n && !wr_chip_sel_n; // RULE_06 RULE_07
    next_st.wen_s2  = st.wen_s1; // RULE_04
    next_st.rise_s1 = wr_data_rise;
    next_st.rise_s2 = st.rise_s1;
    next_st.fall_s1 = wr_data_fall;
    next_st.fall_s2 = st.fall_s1;
    next_st.rsel_s1 = read_queue_select;
    next_st.rsel_s2 = st.rsel_s1;
    next_st.ren_s1  = !rd_en_n && !rd_chip_sel_n; // RULE_13
    next_st.ren_s2  = st.ren_s1;

    // Configuration is caught once the mode pins have crossed their synchronisers
    unique case (st.cfg)
      MQW_CFG_LATCH: begin
        if (st.settle == CFG_SETTLE) begin
          next_st.ft  = st.mode_s2; // RULE_14
          next_st.ddr = st.ddr_s2;
          next_st.cfg = MQW_CFG_RUN;
        end else begin
          next_st.settle = st.settle + 2'h1;
        end
      end
      MQW_CFG_RUN: begin
        next_st.cfg = MQW_CFG_RUN;
      end
    endcase

    // Read side: a pending fall-through word takes the single read slot first
    for (int i = NQ - 1; i >= 0; i--) begin
      if (st.ft_pend[i]) begin
        ft_found = 1'b1;
        ft_q     = QSEL_W'(i);
      end
    end
    if (st.cfg == MQW_CFG_RUN && fifo_room) begin
      if (ft_found) begin
        pop_go = 1'b1; // RULE_10
        pop_q  = ft_q;
        next_st.ft_pend[ft_q] = 1'b0;
        next_st.oready[ft_q]  = 1'b1;
        next_st.rrefused      = st.ren_s2;
      end else if (st.ren_s2) begin
        user_rd = 1'b1;
      end
    end else if (st.ren_s2) begin
      next_st.rrefused = 1'b1;
    end

    if (user_rd) begin
      if (st.cnt[st.rsel_s2] != '0) begin
        pop_go = 1'b1; // RULE_12 RULE_13
        pop_q  = st.rsel_s2;
        if (st.ft) begin
          next_st.oready[st.rsel_s2] = 1'b1;
        end
      end else if (st.ft && st.oready[st.rsel_s2]) begin
        next_st.oready[st.rsel_s2] = 1'b0;
      end else begin
        next_st.rrefused = 1'b1;
      end
    end

    if (pop_go) begin
      next_st.rptr[pop_q] = st.rptr[pop_q] + AW'(1);
      next_st.cnt[pop_q]  = st.cnt[pop_q] - (AW+1)'(1);
    end
    next_st.rp_valid = pop_go;
    next_st.rp_queue = pop_q;

    // Write commit: any queue, every clock, no turnaround between queues
    if (st.cfg == MQW_CFG_RUN && st.wen_s2) begin // RULE_03 RULE_09
      cnt_eff = next_st.cnt[wq];
      wr_ok   = cnt_eff < queue_cap(st.ddr); // RULE_16
      if (wr_ok) begin
        mem_we    = 1'b1; // RULE_05
        mem_waddr = mem_addr(wq, st.wptr[wq]); // RULE_01
        mem_wdata = st.ddr ? {st.fall_s2, st.rise_s2} : {DATA_W'(0), st.rise_s2}; // RULE_15
        next_st.wptr[wq] = st.wptr[wq] + AW'(1);
        next_st.cnt[wq]  = cnt_eff + (AW+1)'(1);
        if (st.ft && st.cnt[wq] == '0 && !st.oready[wq] && !st.ft_pend[wq]) begin
          next_st.ft_pend[wq] = 1'b1; // RULE_10 RULE_11
        end
      end else begin
        next_st.wrefused = 1'b1; // RULE_16
      end
    end

    // Composite input-ready for the queue on the write pipeline's commit stage
    next_st.ir = (next_st.cfg == MQW_CFG_RUN) &&
                 (next_st.cnt[st.wsel_s2] < queue_cap(next_st.ddr)); // RULE_16
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st     <= '0;
      st.cfg <= MQW_CFG_LATCH;
    end else begin
      st <= next_st;
    end
  end

  // Queue storage and registered read port
  always_ff @(posedge clock) begin
    if (mem_we) begin
      qmem[mem_waddr] <= mem_wdata;
    end
    if (pop_go) begin
      mem_rd <= qmem[mem_addr(pop_q, st.rptr[pop_q])];
    end
  end

  // Output stream buffer toward the read side
  mqw_fifo #(
    .WIDTH (OW),
    .DEPTH (OUT_FIFO_DEPTH)
  ) u_out_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (st.rp_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({st.rp_queue, mem_rd}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  ({out_queue, out_data}),
    .level     (fifo_level)
  );

  assign input_ready_flag  = st.ir;
  assign output_ready_flag = st.oready;
  assign fall_through_mode = st.ft;
  assign double_rate_mode  = st.ddr;
  assign write_refused     = st.wrefused;
  assign read_refused      = st.rrefused;

  always_comb begin
    for (int i = 0; i < NQ; i++) begin
      queue_empty[i] = (st.cnt[i] == '0);
    end
  end
endmodule // mqw_write_port
`default_nettype wire

// ===== test/mqw_sink.sv
`timescale 1ns/10ps
`default_nettype none
module mqw_sink (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic slow,
  output logic      out_ready
);
  // Takes every word at once, or stalls at random when slow
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) out_ready <= 1'h0;
    else out_ready <= !slow || ($urandom % 3 == 0);
  end
endmodule // mqw_sink
`default_nettype wire

// ===== test/mqw_write_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
module mqw_write_port_chk
  import mqw_pkg::*;
#(
  parameter int DATA_W = 40
) (
  input wire logic [1:0]          write_queue_select,
  input wire logic                clock,
  input wire logic                reset_n,
  input wire logic                wr_en_n,
  input wire logic                wr_chip_sel_n,
  input wire logic                rd_en_n,
  input wire logic                rd_chip_sel_n,
  input wire logic [2*DATA_W-1:0] out_data,
  input wire logic [1:0]          out_queue,
  input wire logic                out_valid,
  input wire logic                out_ready,
  input wire logic                input_ready_flag,
  input wire logic [3:0]          queue_empty,
  input wire logic [3:0]          output_ready_flag,
  input wire logic                fall_through_mode,
  input wire logic                double_rate_mode,
  input wire logic                write_refused,
  input wire logic                read_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire wr_act = !wr_en_n && !wr_chip_sel_n;
  wire rd_act = !rd_en_n && !rd_chip_sel_n;

  a_commit_two: assert property (wr_act && input_ready_flag && queue_empty[write_queue_select]
    && !$past(wr_act) && !$past(wr_act, 2) |-> ##2 queue_empty[$past(write_queue_select, 2)]
    ##1 !queue_empty[$past(write_queue_select, 3)]) else $error("commit timing wrong");
  a_fall_four: assert property (wr_act && input_ready_flag && fall_through_mode && !out_valid
    && queue_empty == 4'hF && output_ready_flag == 4'h0 && !$past(wr_act) && !$past(wr_act, 2)
    |-> !out_valid[*5] ##1 out_valid) else $error("fall-through word late or early");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid
    && $stable(out_data) && $stable(out_queue)) else $error("output word dropped");
  a_refuse_cause: assert property (write_refused |-> $past(wr_act, 3))
    else $error("refusal without write");
  a_mode_hold: assert property ($past(input_ready_flag) |-> $stable(fall_through_mode)
    && $stable(double_rate_mode)) else $error("mode changed in run");
  a_empty_cause: assert property ((|($past(queue_empty) & ~queue_empty)) |-> $past(wr_act, 3))
    else $error("queue filled without enabled write");
  a_std_no_fall: assert property (!fall_through_mode && $rose(out_valid) |->
    $past(rd_act, 3) || $past(rd_act, 4) || $past(rd_act, 5)) else $error("word fell through");
  a_read_cause: assert property (read_refused |->
    $past(rd_act, 2) || $past(rd_act, 3) || $past(rd_act, 4)) else $error("read refusal stray");
  c_fall: cover property (out_valid && out_ready && fall_through_mode);
  c_wref: cover property (write_refused);
  c_rref: cover property (read_refused);
endmodule // mqw_write_port_chk
bind mqw_write_port mqw_write_port_chk #(.DATA_W(DATA_W)) u_chk (.write_queue_select, .clock,
  .reset_n, .wr_en_n, .wr_chip_sel_n, .rd_en_n, .rd_chip_sel_n, .out_data, .out_queue, .out_valid,
  .out_ready, .input_ready_flag, .queue_empty, .output_ready_flag, .fall_through_mode,
  .double_rate_mode, .write_refused, .read_refused);
`default_nettype wire

// ===== test/mqw_write_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mqw_write_port_tb;
  import mqw_pkg::*;
  localparam int DW = 8;
  localparam int EW = 2*DW+2;
  logic clock = 0, reset_n = 0, wr_en_n = 1, wr_chip_sel_n = 1, rd_en_n = 1, rd_chip_sel_n = 1;
  logic ddr = 0, ft = 0, slow = 0, out_valid, out_ready, irf, ftm, ddrm, wref, rref;
  logic [1:0] wq = 0, rq = 0, oq;
  logic [DW-1:0] dr = 0, df = 0;
  logic [2*DW-1:0] od;
  logic [3:0] qe, orf;
  logic [EW-1:0] exp_q[$];
  int n_fail = 0, num_checks = 0, n_wref = 0, n_rref = 0;

  mqw_write_port #(.DATA_W(DW), .QUEUE_DEPTH(4)) DUT (.clock, .reset_n,
    .write_queue_select(wq), .wr_en_n, .wr_chip_sel_n, .wr_data_rise(dr), .wr_data_fall(df),
    .write_double_rate_sel(ddr), .mode_serial_in_pin(ft), .read_queue_select(rq), .rd_en_n,
    .rd_chip_sel_n, .out_data(od), .out_queue(oq), .out_valid, .out_ready,
    .input_ready_flag(irf), .queue_empty(qe), .output_ready_flag(orf), .fall_through_mode(ftm),
    .double_rate_mode(ddrm), .write_refused(wref), .read_refused(rref));
  mqw_sink u_sink (.clock, .reset_n, .slow, .out_ready);

  initial forever #4 clock = ~clock;

  task automatic chk(input logic [EW-1:0] seen, input logic [EW-1:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst(input logic f, input logic d);
    @(posedge clock);
    reset_n <= 0;
    ft <= f;
    ddr <= d;
    slow <= d;
    repeat (4) @(posedge clock);
    reset_n <= 1;
    repeat (6) @(posedge clock);
  endtask
  task automatic wr(input logic [1:0] q, input logic [DW-1:0] r, input logic [DW-1:0] f);
    @(posedge clock);
    wq <= q;
    dr <= r;
    df <= f;
    wr_en_n <= 0;
    wr_chip_sel_n <= 0;
  endtask
  task automatic rd(input logic [1:0] q);
    @(posedge clock);
    rq <= q;
    rd_en_n <= 0;
    rd_chip_sel_n <= 0;
  endtask
  task automatic idle(input int n);
    @(posedge clock);
    wr_en_n <= 1;
    rd_en_n <= 1;
    repeat (n) @(posedge clock);
  endtask
  task automatic note(input logic [1:0] q, input logic [DW-1:0] r, input logic [DW-1:0] f);
    exp_q.push_back({q, f, r});
  endtask

  // Every word taken by the sink must be the oldest one expected
  always @(posedge clock) begin
    if (reset_n && out_valid && out_ready) begin
      if (exp_q.size() == 0) chk({oq, od}, '1);
      else chk({oq, od}, exp_q.pop_front());
    end
    if (wref) n_wref++;
    if (rref) n_rref++;
  end

  initial begin
    logic [DW-1:0] d[4];
    void'($urandom(32'h190B));
    rst(1, 0);
    chk(ftm, 1);
    for (int i = 0; i < 4; i++) begin
      d[i] = DW'($urandom);
      note(i[1:0], d[i], '0);
      wr(i[1:0], d[i], DW'($urandom));
    end
    idle(12);
    chk(EW'(exp_q.size()), 0);
    d[0] = DW'($urandom);
    wr(1, d[0], '0);
    idle(10);
    chk(out_valid, 0);
    note(1, d[0], '0);
    rd(1);
    idle(10);
    rst(0, 1);
    chk(ddrm, 1);
    @(posedge clock);
    wq <= 0;
    wr_en_n <= 0;
    wr_chip_sel_n <= 1;
    for (int i = 0; i < 4; i++) begin
      d[i] = DW'($urandom);
      wr(i == 0 ? 2'h2 : 2'h3, d[i], ~d[i]);
    end
    idle(10);
    chk(irf, 0);
    chk(out_valid, 0);
    note(2, d[0], ~d[0]);
    note(3, d[1], ~d[1]);
    note(3, d[2], ~d[2]);
    rd(2);
    rd(3);
    rd(3);
    rd(0);
    idle(30);
    chk(irf, 1);
    chk(n_wref, 1);
    chk(n_rref, 1);
    chk(EW'(exp_q.size()), 0);
    conclude();
  end

  initial begin
    #(8 * 2000);
    n_fail++;
    conclude();
  end
endmodule // mqw_write_port_tb
`default_nettype wire
